// [crt_pkg.sv]
// package: format constants for the raster timing generator
// ----------------------------------------------------------------------------
// Functional notes
// - cell is 7x10 dots/lines in variant one, 9x12 in variants two and three
// - visible area 80x24, 32x16 or 80x25 characters by variant
// - frame totals 260/312 lines for variants one and two, 320/384 for three
// - vsync starts 4/30, 27/53 or 0/32 lines after vblank start
// - vsync lasts 10 lines in variant one, 3 in the others
// - vblank start to video is 20/72, 68/120 or 20/84 lines
// - scan line spans 100, 50 or 102 character times; extra is hblank
// - hsync starts 0, 6 or 5 character times after hblank start
// - hsync width 43 (unconfirmed), 4 or 9 character times
// - line buffer clock low 4 dot periods in variant one, 5 otherwise
// - vblank ends 1 line before video in variants one/three, 0 in two
// - cursor enable covers every scan line of the cursor row
// - only variant two serrates hsync during vsync, pulses 4 wide
// - hsync active high in variants one/three, low in two
// - vsync active low in variants one/two, high in three
// - vblank output is active high in every variant
// - line counter forced to zero one full row before video
// - address holds last char plus one in hblank, reloads 3 before video
// - address mode picks last or first line for recirculate and rollover
// - vsync transitions only at the start of horizontal blanking
// ----------------------------------------------------------------------------
package crt_pkg;

    localparam int CRT_NVAR = 3;
    localparam logic [1:0] CRT_VAR_ONE = 2'h0;
    localparam logic [1:0] CRT_VAR_TWO = 2'h1;
    localparam logic [1:0] CRT_VAR_THREE = 2'h2;
    localparam logic [11:0] CRT_ADDR_RESET = 12'h000;

    typedef logic [7:0] crt_byte_t;
    typedef logic [8:0] crt_line_t;

    // ------------------------------------------------------------------------
    // per-variant tables, index 0..2
    // ------------------------------------------------------------------------
    localparam crt_byte_t CRT_CELL_W [CRT_NVAR] = '{8'h07, 8'h09, 8'h09};
    localparam crt_byte_t CRT_CELL_H [CRT_NVAR] = '{8'h0a, 8'h0c, 8'h0c};
    localparam crt_byte_t CRT_COLS [CRT_NVAR] = '{8'h50, 8'h20, 8'h50};
    localparam crt_byte_t CRT_ROWS [CRT_NVAR] = '{8'h18, 8'h10, 8'h19};
    localparam crt_line_t CRT_TOT60 [CRT_NVAR] = '{9'h104, 9'h104, 9'h140};
    localparam crt_line_t CRT_TOT50 [CRT_NVAR] = '{9'h138, 9'h138, 9'h180};
    localparam crt_line_t CRT_VSD60 [CRT_NVAR] = '{9'h004, 9'h01b, 9'h000};
    localparam crt_line_t CRT_VSD50 [CRT_NVAR] = '{9'h01e, 9'h035, 9'h020};
    localparam crt_line_t CRT_VSW [CRT_NVAR] = '{9'h00a, 9'h003, 9'h003};
    localparam crt_line_t CRT_VBI60 [CRT_NVAR] = '{9'h014, 9'h044, 9'h014};
    localparam crt_line_t CRT_VBI50 [CRT_NVAR] = '{9'h048, 9'h078, 9'h054};
    localparam crt_byte_t CRT_HTOT [CRT_NVAR] = '{8'h64, 8'h32, 8'h66};
    localparam crt_byte_t CRT_HSD [CRT_NVAR] = '{8'h00, 8'h06, 8'h05};
    localparam crt_byte_t CRT_HSW [CRT_NVAR] = '{8'h2b, 8'h04, 8'h09};
    localparam crt_byte_t CRT_LBC_LOW [CRT_NVAR] = '{8'h04, 8'h05, 8'h05};
    localparam crt_line_t CRT_VBSTOP [CRT_NVAR] = '{9'h001, 9'h000, 9'h001};
    localparam logic CRT_SERR_EN [CRT_NVAR] = '{1'b0, 1'b1, 1'b0};
    localparam crt_byte_t CRT_SERR_W = 8'h04;
    localparam logic CRT_HS_ACT [CRT_NVAR] = '{1'b1, 1'b0, 1'b1};
    localparam logic CRT_VS_ACT [CRT_NVAR] = '{1'b0, 1'b0, 1'b1};
    localparam logic CRT_VB_ACT = 1'b1;
    localparam crt_byte_t CRT_RELOAD_LEAD = 8'h03;

endpackage

// [crt_raster_timing.sv]
// module: raster timing generator for three mask formats
`timescale 1ns/1ps
module crt_raster_timing
    import crt_pkg::*;
#(
    parameter logic [1:0] VARIANT = crt_pkg::CRT_VAR_ONE
) (
    // clock and reset (clk_sys is the dot clock)
    input wire logic clk_sys,
    input wire logic rst_n,
    // configuration
    input wire logic refreshSel60hz,
    input wire logic addrMode,
    input wire logic [11:0] rowStartValue,
    input wire logic [4:0] cursorRow,
    // video timing outputs
    output logic hSync,
    output logic vSync,
    output logic vBlank,
    output logic hBlank,
    output logic cursorEnable,
    output logic lineBufClk,
    output logic recircEnable,
    output logic charStrobe,
    output logic [3:0] lineCount,
    output logic [11:0] addrOut
);
    import crt_pkg::*;

    // ------------------------------------------------------------------------
    // format selection
    // ------------------------------------------------------------------------
    localparam int V = int'(VARIANT);
    localparam crt_byte_t CW = CRT_CELL_W[V];
    localparam crt_byte_t CH = CRT_CELL_H[V];
    localparam crt_byte_t HT = CRT_HTOT[V];
    localparam crt_byte_t COLS = CRT_COLS[V];
    localparam crt_byte_t HS0 = COLS + CRT_HSD[V];
    localparam crt_byte_t HS1 = HS0 + CRT_HSW[V];
    // a pulse longer than the blanking gap runs on into the start of the next line
    localparam crt_byte_t HS_WRAP = (HS1 > HT) ? HS1 - HT : 8'h00;
    // second serration sits half a line later, folded back into the line
    localparam crt_byte_t SER2 = (HS0 + (HT >> 1) >= HT) ? HS0 + (HT >> 1) - HT : HS0 + (HT >> 1);
    localparam crt_byte_t RELOAD_AT = HT - CRT_RELOAD_LEAD;

    typedef struct packed {
        logic [7:0] dot;
        logic [7:0] col;
        logic [8:0] line;
        logic [3:0] scan;
        logic [4:0] row;
        logic [11:0] addr;
        logic [11:0] rowBase;
        logic sel60;
        logic hSync;
        logic vSync;
        logic vBlank;
        logic hBlank;
        logic cursor;
        logic lbc;
        logic recirc;
        logic strobe;
    } crt_state_s;

    crt_state_s s_q, s_d;

    logic [8:0] tot, vsd, vbi, vidStart, vidEnd, lineNext;
    logic [7:0] colNext;
    logic charEnd, lineEnd, frameEnd, inVideo, vsAct, hsAct, serr, lastScan, rollScan;
    logic vsWin, nextRoll;

    always_comb begin
        s_d = s_q;
        nextRoll = 1'b0;
        tot = s_q.sel60 ? CRT_TOT60[V] : CRT_TOT50[V];
        vsd = s_q.sel60 ? CRT_VSD60[V] : CRT_VSD50[V];
        vbi = s_q.sel60 ? CRT_VBI60[V] : CRT_VBI50[V];
        // line 0 is the start of vertical blanking; video follows the blank gap
        vidStart = vbi;
        vidEnd = tot;
        charEnd = (s_q.dot == CW - 8'h01);
        lineEnd = charEnd && (s_q.col == HT - 8'h01);
        frameEnd = lineEnd && (s_q.line == tot - 9'h001);
        colNext = lineEnd ? 8'h00 : s_q.col + 8'h01;
        lineNext = frameEnd ? 9'h000 : s_q.line + 9'h001;
        inVideo = (s_q.line >= vidStart) && (s_q.line < vidEnd);
        lastScan = (s_q.scan == 4'(CH - 8'h01));
        rollScan = addrMode ? (s_q.scan == 4'h0) : lastScan;

        // ---- dot divider: character clock ----
        s_d.dot = charEnd ? 8'h00 : s_q.dot + 8'h01;
        s_d.lbc = (s_d.dot >= CRT_LBC_LOW[V]);
        s_d.strobe = charEnd;

        if (charEnd) begin
            s_d.col = colNext;
            // hblank from the column after the last visible one onward
            s_d.hBlank = (colNext >= COLS);
            // horizontal address: count in video, hold last+1 in blanking
            if (colNext == RELOAD_AT) begin
                // base moves on at the reload point, so the next line already starts from it
                if (s_q.line == vidStart - 9'h001) begin
                    s_d.rowBase = rowStartValue;
                end else if (inVideo && rollScan) begin
                    s_d.rowBase = s_q.rowBase + 12'(COLS);
                end
                s_d.addr = s_d.rowBase;
            end else if (colNext != 8'h00 && colNext <= COLS) begin
                s_d.addr = s_q.addr + 12'h001;
            end
        end

        if (lineEnd) begin
            s_d.line = lineNext;
            // refresh select is taken only at the frame boundary
            if (frameEnd) begin
                s_d.sel60 = refreshSel60hz;
            end
            // row and scan counting; one row ahead of video scan is zeroed and row is set to 5'h1f
            if (lineNext == vidStart - 9'(CH)) begin
                s_d.scan = 4'h0;
                s_d.row = 5'h1f;
            end else if (s_d.scan == 4'(CH - 8'h01)) begin
                s_d.scan = 4'h0;
                s_d.row = s_q.row + 5'h01;
            end else begin
                s_d.scan = s_q.scan + 4'h1;
            end
            if (lineNext == vidStart) begin
                s_d.row = 5'h00;
                s_d.scan = 4'h0;
            end
            // vblank covers frame start up to its stop point before video
            s_d.vBlank = (lineNext < vidStart - CRT_VBSTOP[V]) ? CRT_VB_ACT : ~CRT_VB_ACT;
            // the flag belongs to the line now starting, so judge it by that line's scan
            nextRoll = addrMode ? (s_d.scan == 4'h0) : (s_d.scan == 4'(CH - 8'h01));
            s_d.recirc = ~((lineNext >= vidStart) && (lineNext < vidEnd) && nextRoll);
        end

        // vsync changes only at hblank start of a line
        vsWin = (s_q.line >= vsd) && (s_q.line < vsd + CRT_VSW[V]);
        if (charEnd && colNext == COLS) begin
            s_d.vSync = vsWin ? CRT_VS_ACT[V] : ~CRT_VS_ACT[V];
        end
        vsAct = (s_q.vSync == CRT_VS_ACT[V]);

        // horizontal sync with optional serrations while vsync is active
        // the run-on part only extends a pulse already going, so reset never starts a stub
        hsAct = ((colNext >= HS0) && (colNext < HS1))
            || ((colNext < HS_WRAP) && (s_q.hSync == CRT_HS_ACT[V]));
        serr = CRT_SERR_EN[V] && vsAct && ((colNext >= HS0 && colNext < HS0 + CRT_SERR_W)
            || (colNext >= SER2 && colNext < SER2 + CRT_SERR_W));
        if (charEnd) begin
            s_d.hSync = (CRT_SERR_EN[V] && vsAct) ? (serr ? CRT_HS_ACT[V] : ~CRT_HS_ACT[V])
                : (hsAct ? CRT_HS_ACT[V] : ~CRT_HS_ACT[V]);
        end

        // cursor enable on every scan line of the cursor row
        s_d.cursor = inVideo && (s_q.row == cursorRow);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.sel60 <= 1'b1;
            s_q.hSync <= ~CRT_HS_ACT[V];
            s_q.vSync <= ~CRT_VS_ACT[V];
            s_q.vBlank <= CRT_VB_ACT;
            s_q.recirc <= 1'b1;
            s_q.addr <= CRT_ADDR_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs straight from the state register
    // ------------------------------------------------------------------------
    assign hSync = s_q.hSync;
    assign vSync = s_q.vSync;
    assign vBlank = s_q.vBlank;
    assign hBlank = s_q.hBlank;
    assign cursorEnable = s_q.cursor;
    assign lineBufClk = s_q.lbc;
    assign recircEnable = s_q.recirc;
    assign charStrobe = s_q.strobe;
    assign lineCount = s_q.scan;
    assign addrOut = s_q.addr;

endmodule

// [crt_raster_timing_sva.sv]
// checker: port-level timing assertions for the raster generator
`timescale 1ns/1ps
module crt_raster_timing_sva
    import crt_pkg::*;
#(
    parameter logic [1:0] VARIANT = CRT_VAR_ONE
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // observed timing outputs
    input wire logic hSync, vSync, vBlank, hBlank, cursorEnable, lineBufClk, charStrobe,
    input wire logic [3:0] lineCount,
    input wire logic recircEnable,
    input wire logic [11:0] addrOut,
    // configuration seen at the pins
    input wire logic addrMode
);
    localparam logic HS = CRT_HS_ACT[VARIANT];
    localparam logic VS = CRT_VS_ACT[VARIANT];
    int dots, lows, hsDots, chars, vis;
    logic hbQ, seen;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // counters restart at each char or line, so one bad period shows at once
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dots <= 0;
            lows <= 0;
            hsDots <= 0;
            chars <= 0;
            vis <= 0;
            hbQ <= 1'b0;
            seen <= 1'b0;
        end else begin
            hbQ <= hBlank;
            dots <= charStrobe ? 0 : dots + 1;
            lows <= charStrobe ? int'(!lineBufClk) : lows + int'(!lineBufClk);
            hsDots <= (hSync == HS) ? hsDots + 1 : 0;
            chars <= (hBlank && !hbQ) ? int'(charStrobe) : chars + int'(charStrobe);
            vis <= (hBlank && !hbQ) ? 0 : vis + int'(charStrobe && !hBlank);
            seen <= seen | (hBlank && !hbQ);
        end
    end
    a_char_period: assert property (charStrobe && seen |-> dots == CRT_CELL_W[VARIANT] - 1)
        else $error("character period wrong");
    a_lbc_low: assert property (charStrobe && seen |-> lows == CRT_LBC_LOW[VARIANT])
        else $error("line buffer clock low time wrong");
    // the first line after reset has no strobe at column zero, so it is skipped
    a_hblank_cols: assert property ($rose(hBlank) && seen |-> vis == CRT_COLS[VARIANT])
        else $error("visible character count wrong");
    a_line_chars: assert property ($rose(hBlank) && seen |-> chars == CRT_HTOT[VARIANT])
        else $error("character times per line wrong");
    a_hsync_start: assert property (CRT_HSD[VARIANT] == 0 && $rose(hBlank) |-> hSync == HS)
        else $error("hsync not at hblank start");
    // serrated pulses take their width from CRT_SERR_W, so this only watches formats without them
    a_hsync_width: assert property (!CRT_SERR_EN[VARIANT] && $fell(hSync == HS) |->
        hsDots == CRT_HSW[VARIANT] * CRT_CELL_W[VARIANT]) else $error("hsync width wrong");
    a_vsync_edge: assert property ($changed(vSync) |-> $rose(hBlank)) else $error("vsync edge off hblank");
    a_vsync_blank: assert property (vSync == VS |-> vBlank) else $error("vsync outside vblank");
    a_cursor_row: assert property ($rose(cursorEnable) |-> lineCount == 4'h0)
        else $error("cursor starts mid row");
    a_addr_step: assert property (charStrobe && $past(!hBlank) |-> addrOut == 12'($past(addrOut) + 12'h001))
        else $error("address did not step by one");
    a_recirc_line: assert property ($fell(recircEnable) |->
        lineCount == (addrMode ? 4'h0 : 4'(CRT_CELL_H[VARIANT] - 8'h01)))
        else $error("recirculate low on wrong scan line");
endmodule
bind crt_raster_timing crt_raster_timing_sva #(.VARIANT(VARIANT)) i_crt_raster_timing_sva (.clk_sys, .rst_n,
    .hSync, .vSync, .vBlank, .hBlank, .cursorEnable, .lineBufClk, .charStrobe, .lineCount, .recircEnable,
    .addrOut, .addrMode);

// [crt_monitor_model.sv]
// partner: monitor that times sync and blanking edges in scan lines
`timescale 1ns/1ps
module crt_monitor_model (
    // generator outputs at the monitor input
    input wire logic clk_sys, rst_n, hSync, vSync, vBlank, cursorEnable,
    input wire logic [11:0] addrOut,
    // scan-line indices, counted in hsync rises up to and including the same edge
    output int lineIdx, vsOn, vsOff, vbOff, curLines,
    // address held in blanking on the first cursor line
    output int curAddr
);
    logic hsQ, vsQ, vbQ;
    wire logic rise = hSync && !hsQ;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {hsQ, vsQ, vbQ} <= 3'b011;
            {lineIdx, vsOn, vsOff, vbOff, curLines, curAddr} <= '0;
        end else begin
            {hsQ, vsQ, vbQ} <= {hSync, vSync, vBlank};
            lineIdx <= lineIdx + int'(rise);
            if (vsQ && !vSync) vsOn <= lineIdx + int'(rise);
            if (!vsQ && vSync) vsOff <= lineIdx + int'(rise);
            if (vbQ && !vBlank) vbOff <= lineIdx + int'(rise);
            if (cursorEnable && rise) curLines <= curLines + 1;
            if (cursorEnable && rise && curLines == 0) curAddr <= int'(addrOut);
        end
    end
endmodule

// [crt_raster_timing_test.sv]
// testbench: first-frame timing of format one, with a reset in mid-frame
`timescale 1ns/1ps
module crt_raster_timing_test;
    import crt_pkg::*;
    logic clk_sys, rst_n, refreshSel60hz, addrMode, hSync, vSync, vBlank, hBlank;
    logic cursorEnable, lineBufClk, recircEnable, charStrobe;
    logic [11:0] rowStartValue, addrOut;
    logic [4:0] cursorRow;
    logic [3:0] lineCount;
    int lineIdx, vsOn, vsOff, vbOff, curLines, curAddr, err_total, n_tests;
    int seed = 32'h91e6;
    crt_raster_timing #(.VARIANT(CRT_VAR_ONE)) i_crt_raster_timing (.clk_sys, .rst_n, .refreshSel60hz, .addrMode,
        .rowStartValue, .cursorRow, .hSync, .vSync, .vBlank, .hBlank, .cursorEnable, .lineBufClk, .recircEnable,
        .charStrobe, .lineCount, .addrOut);
    crt_monitor_model i_crt_monitor_model (.clk_sys, .rst_n, .hSync, .vSync, .vBlank, .cursorEnable, .lineIdx,
        .vsOn, .vsOff, .vbOff, .curLines, .addrOut, .curAddr);
    // in blanking the address rests one past the last character of the row
    function automatic logic [31:0] exp_addr(input logic [11:0] start, input logic [4:0] row);
        return 32'(12'(start + 12'(CRT_COLS[0]) * (12'(row) + 12'h001)));
    endfunction
    function automatic logic [31:0] exp_line(input int which);
        case (which)
            0: return CRT_VSD60[0] + 1;
            1: return CRT_VSD60[0] + CRT_VSW[0] + 1;
            2: return CRT_VBI60[0] - CRT_VBSTOP[0];
            default: return CRT_CELL_H[0];
        endcase
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // two passes of at most 62 lines of 700 dots each fit well inside this span
    initial begin
        #1000000;
        err_total++;
        close_out();
    end
    initial begin
        rst_n = 1'b0;
        {refreshSel60hz, addrMode, rowStartValue, cursorRow} = '0;
        for (int pass = 0; pass < 2; pass++) begin
            @(negedge clk_sys);
            rst_n = 1'b0;
            refreshSel60hz = 1'($random(seed));
            addrMode = 1'($random(seed));
            rowStartValue = 12'($random(seed));
            cursorRow = (pass == 0) ? 5'h00 : 5'($unsigned($random(seed)) % 3 + 1);
            repeat (2) @(negedge clk_sys);
            rst_n = 1'b1;
            // first frame always runs the 60 Hz counts, whatever the select says
            for (int i = 0; i < 50000 && lineIdx < 32 + 10 * int'(cursorRow); i++) @(negedge clk_sys);
            check(vsOn, exp_line(0));
            check(vsOff, exp_line(1));
            check(vbOff, exp_line(2));
            check(curLines, exp_line(3));
            check(curAddr, exp_addr(rowStartValue, cursorRow));
            $display("test %0d done: cursor row %0d", pass, cursorRow);
        end
        close_out();
    end
endmodule
